// file: core/osca_top.sv
/*
 On/off cycle-by-cycle power switch control with current-limit
 selection, lockouts, auto-restart and line undervoltage gating.
 Assumes all comparator inputs are asynchronous levels from analog
 circuits; they are synchronised here. Single 50 MHz clock.
*/
// Overview of operation
// RULE1: Block switching below 4.8 V supply until it climbs back to 5.8 V.
// RULE2: Over-temperature disables switch until die cools by the hysteresis.
// RULE3: Over-current turns switch off for rest of the oscillator cycle.
// RULE4: Ignore current-limit comparator during blanking after every turn-on.
// RULE5: Fault counter advances per oscillator cycle, cleared when enable pulled low.
// RULE6: No enable-low for 50 ms stops switching for 850 ms.
// RULE7: Alternate enabled and disabled periods while fault persists.
// RULE8: Line undervoltage during auto-restart off freezes the fault counter. Code freezes the off-time counter off_cnt_r instead.
// RULE9: Power-up or auto-restart start switching only with line current sufficient.
// RULE10: Hold supply at 4.8 V during power-up while line undervoltage exists.
// RULE11: Tiny line-sense current means resistor absent; line undervoltage disabled.
// RULE12: Switch on at cycle start, off at current limit or max duty.
// RULE13: A started cycle always completes regardless of enable changes.
// RULE14: Feedback holds enable high below reference, pulls low above target.
// RULE15: Clock runs always; enable sampled each cycle start; pattern picks limit.
// RULE16: Heavy load gets full current limit; lighter load gets reduced limit.
// RULE17: Limit steps down at medium/light load, further at very light load.
// RULE18: At power-down switch 50 ms after regulation loss, then stay off.
// RULE19: Enable decision captured at cycle-start edge, held whole cycle.
// RULE20: Over 240 uA out of enable input reads as disable.
// RULE21: Oscillator at 132 kHz gives cycle-start and maximum duty signals.
// RULE22: Analog comparator results enter as synchronised single bits.
// RULE23: Current limit is a three-setting selector updated by the load machine.
`include "osca_defines.svh"

module osca_top
  import osca_pkg::*;
#(
  parameter int FAULT_CYC  = `OSCA_FAULT_CYC,
  parameter int OFF_CYC    = `OSCA_OFF_CYC,
  parameter int BLANK_CYC  = `OSCA_BLANK_CYC,
  parameter int UP_RUN     = `OSCA_UP_RUN,
  parameter int DOWN_SKIP  = `OSCA_DOWN_SKIP
) (
  // Clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_rst,
  // Analog comparator results, asynchronous
  input  wire logic          i_supply_low,
  input  wire logic          i_supply_ok,
  input  wire logic          i_over_temp,
  input  wire logic          i_temp_cooled,
  input  wire logic          i_over_current,
  input  wire logic          i_enable_undervoltage_input,
  input  wire logic          i_line_ok,
  input  wire logic          i_sense_absent,
  // Power switch and supply control
  output logic               o_switch_on,
  output logic               o_supply_hold,
  output osca_ilim_type      o_ilim_sel,
  // Status
  output logic               o_cycle_start,
  output logic               o_max_duty_limit,
  output logic               o_supply_lockout,
  output logic               o_thermal_lockout,
  output logic               o_restart_off,
  output logic               o_line_uv
);

  // Synchroniser
  logic [`OSCA_SYNC_W-1:0] sync1_r;
  logic [`OSCA_SYNC_W-1:0] sync2_r;
  logic                    supply_low;
  logic                    supply_ok;
  logic                    over_temp;
  logic                    temp_cooled;
  logic                    over_cur;
  logic                    en_high;
  logic                    line_ok;
  logic                    sense_absent;
  logic                    en_low;
  logic                    line_uv;

  // Two flops per comparator bit before any logic [RULE22]
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {i_supply_low, i_supply_ok, i_over_temp, i_temp_cooled,
                  i_over_current, i_enable_undervoltage_input, i_line_ok, i_sense_absent};
      sync2_r <= sync1_r;
    end
  end

  assign {supply_low, supply_ok, over_temp, temp_cooled,
          over_cur, en_high, line_ok, sense_absent} = sync2_r;
  // Enable comparator low means more than 240 uA drawn [RULE20]
  assign en_low  = !en_high;
  // Line check is disabled when the sense resistor is absent [RULE11]
  assign line_uv = !sense_absent && !line_ok;

  // Oscillator
  logic cyc_start;
  logic max_duty;

  osca_osc u_osc (
    .i_mclk           (i_mclk),
    .i_rst            (i_rst),
    .o_cycle_start    (cyc_start),
    .o_max_duty_limit (max_duty)
  );

  // Lockouts with hysteresis
  logic supply_lock_r;
  logic supply_lock_nxt;
  logic therm_r;
  logic therm_nxt;
  logic powerup_r;
  logic powerup_nxt;

  // Auto-restart state
  osca_ar_type           ar_r;
  osca_ar_type           ar_nxt;
  logic [`OSCA_AR_W-1:0] fault_cnt_r;
  logic [`OSCA_AR_W-1:0] fault_cnt_nxt;
  logic [`OSCA_AR_W-1:0] off_cnt_r;
  logic [`OSCA_AR_W-1:0] off_cnt_nxt;

  // Switch pulse state
  logic                    go;
  logic                    switch_nxt;
  logic [`OSCA_BLANK_W-1:0] blank_r;
  logic [`OSCA_BLANK_W-1:0] blank_nxt;

  // Current-limit machine
  osca_ilim_type          ilim_nxt;
  logic [`OSCA_RUN_W-1:0] run_r;
  logic [`OSCA_RUN_W-1:0] run_nxt;
  logic [`OSCA_RUN_W-1:0] skip_r;
  logic [`OSCA_RUN_W-1:0] skip_nxt;

  always_comb begin
    supply_lock_nxt = supply_lock_r;
    therm_nxt       = therm_r;
    powerup_nxt     = powerup_r;
    // Lock below 4.8 V, release only at 5.8 V [RULE1]
    if (supply_low) begin
      supply_lock_nxt = 1'b1;
    end else if (supply_ok) begin
      supply_lock_nxt = 1'b0;
    end
    // Trip at high temperature, release after cooling [RULE2]
    if (over_temp) begin
      therm_nxt = 1'b1;
    end else if (temp_cooled) begin
      therm_nxt = 1'b0;
    end
    if (cyc_start && go) begin
      powerup_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      supply_lock_r <= 1'b1;
      therm_r       <= 1'b0;
      powerup_r     <= 1'b1;
    end else begin
      supply_lock_r <= supply_lock_nxt;
      therm_r       <= therm_nxt;
      powerup_r     <= powerup_nxt;
    end
  end

  // Counter counts oscillator cycles in both phases [RULE5] [RULE6] [RULE7]
  always_comb begin
    ar_nxt        = ar_r;
    fault_cnt_nxt = fault_cnt_r;
    off_cnt_nxt   = off_cnt_r;
    unique case (ar_r)
      OSCA_AR_RUN: begin
        if (en_low) begin
          fault_cnt_nxt = '0;
        end else if (cyc_start) begin
          if (fault_cnt_r == `OSCA_AR_W'(FAULT_CYC - 1)) begin
            ar_nxt        = OSCA_AR_OFF;
            off_cnt_nxt   = '0;
            fault_cnt_nxt = '0;
          end else begin
            fault_cnt_nxt = fault_cnt_r + `OSCA_AR_W'(1);
          end
        end
      end
      OSCA_AR_OFF: begin
        // Off time stretched while line undervoltage persists [RULE8] [RULE18]
        if (cyc_start && !line_uv) begin
          if (off_cnt_r == `OSCA_AR_W'(OFF_CYC - 1)) begin
            ar_nxt      = OSCA_AR_RUN;
            off_cnt_nxt = '0;
          end else begin
            off_cnt_nxt = off_cnt_r + `OSCA_AR_W'(1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ar_r        <= OSCA_AR_RUN;
      fault_cnt_r <= '0;
      off_cnt_r   <= '0;
    end else begin
      ar_r        <= ar_nxt;
      fault_cnt_r <= fault_cnt_nxt;
      off_cnt_r   <= off_cnt_nxt;
    end
  end

  // Decision taken only at cycle start and held for the cycle [RULE19] [RULE15]
  assign go = en_high && !supply_lock_r && !therm_r && (ar_r == OSCA_AR_RUN)
              && !(powerup_r && line_uv); // [RULE9]

  always_comb begin
    switch_nxt = o_switch_on;
    blank_nxt  = blank_r;
    if (blank_r != '0) begin
      blank_nxt = blank_r - `OSCA_BLANK_W'(1);
    end
    if (cyc_start) begin
      // Turn on at cycle start only [RULE12]
      switch_nxt = go;
      blank_nxt  = go ? `OSCA_BLANK_W'(BLANK_CYC) : '0;
    end else if (o_switch_on && ((over_cur && blank_r == '0) || max_duty)) begin
      // Off until next cycle start [RULE3] [RULE4] [RULE13]
      switch_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_switch_on <= 1'b0;
      blank_r     <= '0;
    end else begin
      o_switch_on <= switch_nxt;
      blank_r     <= blank_nxt;
    end
  end

  // Steps limit from the run/skip pattern of samples [RULE16] [RULE17] [RULE23]
  always_comb begin
    ilim_nxt = o_ilim_sel;
    run_nxt  = run_r;
    skip_nxt = skip_r;
    if (cyc_start) begin
      if (en_high) begin
        skip_nxt = '0;
        run_nxt  = run_r + `OSCA_RUN_W'(1);
        if (run_r == `OSCA_RUN_W'(UP_RUN - 1)) begin
          run_nxt = '0;
          unique case (o_ilim_sel)
            OSCA_ILIM_LOW:  ilim_nxt = OSCA_ILIM_RED;
            OSCA_ILIM_RED:  ilim_nxt = OSCA_ILIM_FULL;
            default:        ilim_nxt = OSCA_ILIM_FULL;
          endcase
        end
      end else begin
        run_nxt  = '0;
        skip_nxt = skip_r + `OSCA_RUN_W'(1);
        if (skip_r == `OSCA_RUN_W'(DOWN_SKIP - 1)) begin
          skip_nxt = '0;
          unique case (o_ilim_sel)
            OSCA_ILIM_FULL: ilim_nxt = OSCA_ILIM_RED;
            OSCA_ILIM_RED:  ilim_nxt = OSCA_ILIM_LOW;
            default:        ilim_nxt = OSCA_ILIM_LOW;
          endcase
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ilim_sel <= OSCA_ILIM_FULL;
      run_r      <= '0;
      skip_r     <= '0;
    end else begin
      o_ilim_sel <= ilim_nxt;
      run_r      <= run_nxt;
      skip_r     <= skip_nxt;
    end
  end

  // Registered status outputs
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_supply_hold     <= 1'b0;
      o_cycle_start     <= 1'b0;
      o_max_duty_limit  <= 1'b0;
      o_supply_lockout  <= 1'b1;
      o_thermal_lockout <= 1'b0;
      o_restart_off     <= 1'b0;
      o_line_uv         <= 1'b0;
    end else begin
      o_supply_hold     <= powerup_r && line_uv; // [RULE10]
      o_cycle_start     <= cyc_start;
      o_max_duty_limit  <= max_duty;
      o_supply_lockout  <= supply_lock_r;
      o_thermal_lockout <= therm_r;
      o_restart_off     <= (ar_r == OSCA_AR_OFF);
      o_line_uv         <= line_uv;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  chk_supply_block: assert property (supply_lock_r && cyc_start |=> !o_switch_on) // [RULE1]
    else $error("switch on during supply lockout");
  chk_thermal_block: assert property (therm_r && cyc_start |=> !o_switch_on) // [RULE2]
    else $error("switch on during thermal lockout");
  chk_oc_off: assert property (o_switch_on && over_cur && blank_r == '0 && !cyc_start |=> !o_switch_on) // [RULE3]
    else $error("over-current did not end pulse");
  chk_blank_hold: assert property (o_switch_on && blank_r != '0 && !max_duty && !cyc_start |=> o_switch_on) // [RULE4]
    else $error("pulse ended inside blanking");
  chk_fault_clear: assert property (en_low && ar_r == OSCA_AR_RUN |=> fault_cnt_r == '0) // [RULE5]
    else $error("fault counter not cleared by enable low");
  chk_restart_enter: assert property (ar_r == OSCA_AR_RUN && cyc_start && !en_low
                                      && fault_cnt_r == `OSCA_AR_W'(FAULT_CYC - 1) |=> ar_r == OSCA_AR_OFF) // [RULE6]
    else $error("auto-restart off not entered");
  chk_restart_off: assert property (ar_r == OSCA_AR_OFF && cyc_start |=> !o_switch_on) // [RULE7]
    else $error("switching during auto-restart off");
  chk_uv_freeze: assert property (ar_r == OSCA_AR_OFF && line_uv |=> $stable(off_cnt_r)) // [RULE8]
    else $error("off counter moved under line undervoltage");
  chk_powerup_uv: assert property (powerup_r && line_uv && cyc_start |=> !o_switch_on) // [RULE9]
    else $error("power-up start under line undervoltage");
  chk_turn_on: assert property (cyc_start && go |=> o_switch_on ##1 (o_switch_on || max_duty || over_cur)) // [RULE12]
    else $error("enabled cycle did not turn on");
  chk_cycle_done: assert property (!cyc_start && !o_switch_on |=> !o_switch_on) // [RULE13]
    else $error("switch turned on mid-cycle");

endmodule

// file: pkg/osca_defines.svh
/*
 Timing counts and field widths of the on/off switch controller.
 Assumes a 50 MHz master clock; the period, duty and blanking counts are derived from it.
*/
`ifndef OSCA_DEFINES_SVH
`define OSCA_DEFINES_SVH

`define OSCA_MCLK_HZ       50000000
`define OSCA_OSC_HZ        132000
`define OSCA_PERIOD_CYC    (`OSCA_MCLK_HZ / `OSCA_OSC_HZ)
`define OSCA_PHASE_W       9
`define OSCA_MAX_DUTY_PCT  65
`define OSCA_MAX_DUTY_CYC  (`OSCA_PERIOD_CYC * `OSCA_MAX_DUTY_PCT / 100)
`define OSCA_BLANK_NS      200
`define OSCA_BLANK_CYC     ((`OSCA_BLANK_NS * (`OSCA_MCLK_HZ / 1000000) + 999) / 1000)
`define OSCA_BLANK_W       8
`define OSCA_FAULT_MS      50
`define OSCA_FAULT_CYC     (`OSCA_FAULT_MS * `OSCA_OSC_HZ / 1000)
`define OSCA_OFF_MS        850
`define OSCA_OFF_CYC       (`OSCA_OFF_MS * `OSCA_OSC_HZ / 1000)
`define OSCA_AR_W          17
`define OSCA_UP_RUN        4
`define OSCA_DOWN_SKIP     3
`define OSCA_RUN_W         3
`define OSCA_SYNC_W        8

`endif

// file: pkg/osca_pkg.sv
/*
 Types of the on/off switch controller.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package osca_pkg;

  typedef enum logic [1:0] {
    OSCA_ILIM_FULL,
    OSCA_ILIM_RED,
    OSCA_ILIM_LOW
  } osca_ilim_type;

  typedef enum logic {
    OSCA_AR_RUN,
    OSCA_AR_OFF
  } osca_ar_type;

endpackage

// file: core/osca_osc.sv
/*
 Free-running oscillator: cycle-start pulse and maximum duty limit.
 Assumes i_mclk at 50 MHz and a synchronous active-high reset.
*/
`include "osca_defines.svh"

module osca_osc
  import osca_pkg::*;
#(
  parameter int PERIOD_CYC   = `OSCA_PERIOD_CYC,
  parameter int MAX_DUTY_CYC = `OSCA_MAX_DUTY_CYC
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // Timing outputs
  output logic      o_cycle_start,
  output logic      o_max_duty_limit
);

  logic [`OSCA_PHASE_W-1:0] phase_r;
  logic [`OSCA_PHASE_W-1:0] phase_nxt;
  logic                     start_nxt;
  logic                     duty_nxt;

  // Phase wraps every oscillator period [RULE21]
  always_comb begin
    if (phase_r == `OSCA_PHASE_W'(PERIOD_CYC - 1)) begin
      phase_nxt = '0;
    end else begin
      phase_nxt = phase_r + `OSCA_PHASE_W'(1);
    end
    start_nxt = (phase_nxt == '0);
    duty_nxt  = (phase_nxt >= `OSCA_PHASE_W'(MAX_DUTY_CYC));
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      phase_r          <= '0;
      o_cycle_start    <= 1'b0;
      o_max_duty_limit <= 1'b0;
    end else begin
      phase_r          <= phase_nxt;
      o_cycle_start    <= start_nxt;
      o_max_duty_limit <= duty_nxt;
    end
  end

endmodule

// file: sim/osca_opto_model.sv
/*
 Optocoupler feedback model standing in for the secondary side.
 Assumes the bench picks the mode and that i_mclk runs throughout.
*/
module osca_opto_model (
  // Clock and mode: 0 regulate, 1 held high, 2 held low
  input  wire logic       i_mclk,
  input  wire logic [1:0] i_mode,
  // Primary side
  input  wire logic       i_switch_on,
  input  wire logic       i_cycle_start,
  output logic            o_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  int   level = 0;
  logic sw_d  = 1'b0;
  initial o_enable = 1'b0;
  // Each pulse charges the output, each cycle start without a new pulse lets the load drain it
  always @(negedge i_mclk) begin
    sw_d <= i_switch_on;
    if (i_switch_on && !sw_d) level <= level + 4;
    else if (i_cycle_start && level > 0) level <= level - 1;
    case (i_mode)
      2'h0: o_enable <= (level < 8);
      2'h1: o_enable <= 1'b1;
      default: o_enable <= 1'b0;
    endcase
  end
endmodule

// file: sim/test_osca_top.sv
/*
 Self-checking bench of the on/off switch controller.
 Assumes osca_top with shortened fault and off counts.
*/
module test_osca_top
  import osca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FAULT = 8;
  localparam int OFFC  = 12;
  localparam int BLANK = 10;
  localparam int MAXD  = 245;
  logic          i_mclk = 1'b0;
  logic          i_rst = 1'b1;
  logic          i_supply_low = 1'b0;
  logic          i_supply_ok = 1'b0;
  logic          i_over_temp = 1'b0;
  logic          i_temp_cooled = 1'b1;
  logic          i_over_current = 1'b0;
  logic          i_line_ok = 1'b0;
  logic          i_sense_absent = 1'b0;
  logic [1:0]    mode = 2'h1;
  logic          opto_en;
  logic          o_switch_on;
  logic          o_supply_hold;
  osca_ilim_type o_ilim_sel;
  logic          o_cycle_start;
  logic          o_max_duty_limit;
  logic          o_supply_lockout;
  logic          o_thermal_lockout;
  logic          o_restart_off;
  logic          o_line_uv;
  logic          sw_seen = 1'b0;
  logic          off_sw = 1'b0;
  int            errors = 0;
  int            checks_done = 0;
  int            cycles = 0;
  int            w;

  osca_top #(.FAULT_CYC(FAULT), .OFF_CYC(OFFC), .BLANK_CYC(BLANK), .UP_RUN(4), .DOWN_SKIP(3)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_supply_low(i_supply_low), .i_supply_ok(i_supply_ok),
    .i_over_temp(i_over_temp), .i_temp_cooled(i_temp_cooled), .i_over_current(i_over_current),
    .i_enable_undervoltage_input(opto_en), .i_line_ok(i_line_ok), .i_sense_absent(i_sense_absent),
    .o_switch_on(o_switch_on), .o_supply_hold(o_supply_hold), .o_ilim_sel(o_ilim_sel),
    .o_cycle_start(o_cycle_start), .o_max_duty_limit(o_max_duty_limit),
    .o_supply_lockout(o_supply_lockout), .o_thermal_lockout(o_thermal_lockout),
    .o_restart_off(o_restart_off), .o_line_uv(o_line_uv));

  osca_opto_model opto (.i_mclk(i_mclk), .i_mode(mode), .i_switch_on(o_switch_on),
    .i_cycle_start(o_cycle_start), .o_enable(opto_en));

  always #10 i_mclk = ~i_mclk;

  // Switch activity monitors and hang guard
  always @(posedge i_mclk) begin
    cycles++;
    if (o_switch_on === 1'b1) sw_seen = 1'b1;
    if (o_switch_on === 1'b1 && o_restart_off === 1'b1) off_sw = 1'b1;
    if (cycles == 100000) begin
      errors++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic check_in(input string name, input int seen, input int lo, input int hi);
    check(name, 32'(seen >= lo && seen <= hi), 32'h1);
  endtask

  // Returns at the falling edge where the cycle-start pulse shows
  task automatic wait_start();
    int n;
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (o_cycle_start !== 1'b1 && n < 1000);
    check("cycle start", 32'(n < 1000), 32'h1);
  endtask

  task automatic run_starts(input int n, input bit en, input bit chk);
    mode = en ? 2'h1 : 2'h2;
    repeat (n) begin
      wait_start();
      if (chk) check("switch at start", 32'(o_switch_on), 32'(en));
    end
    repeat (2) @(negedge i_mclk);
  endtask

  // Enabled pulse; enable drops at drop_at to show the cycle still completes
  task automatic pulse_width(input int drop_at, output int pw);
    mode = 2'h1;
    wait_start();
    pw = 0;
    while (o_switch_on === 1'b1 && pw < 400) begin
      if (pw == drop_at) mode = 2'h2;
      @(negedge i_mclk);
      pw++;
    end
  endtask

  task automatic count_off(output int n);
    n = 0;
    while (o_restart_off === 1'b1 && n < 60) begin
      wait_start();
      n++;
    end
  endtask

  // Trip, trip released, recovered
  task automatic hyst(input bit th);
    for (int s = 0; s < 3; s++) begin
      if (th) begin
        i_over_temp = (s == 0);
        i_temp_cooled = (s == 2);
      end else begin
        i_supply_low = (s == 0);
        i_supply_ok = (s == 2);
      end
      repeat (5) @(negedge i_mclk);
      check("lockout", 32'(th ? o_thermal_lockout : o_supply_lockout), 32'(s < 2));
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge i_mclk);
    check("lockout in reset", 32'(o_supply_lockout), 32'h1);
    check("switch in reset", 32'(o_switch_on), 32'h0);
    check("limit in reset", 32'(o_ilim_sel), 32'(OSCA_ILIM_FULL));
    i_rst = 1'b0;
    repeat (2) wait_start();
    i_supply_ok = 1'b1;
    repeat (2) wait_start();
    check("lockout off", 32'(o_supply_lockout), 32'h0);
    check("line uv", 32'(o_line_uv), 32'h1);
    check("supply hold", 32'(o_supply_hold), 32'h1);
    check("held off", 32'(sw_seen), 32'h0);
    i_line_ok = 1'b1;
    wait_start();
    check("hold released", 32'(o_supply_hold), 32'h0);
    check("first switch", 32'(o_switch_on), 32'h1);
    mode = 2'h2;
    hyst(1'b0);
    hyst(1'b1);
    $display("test power-up and lockouts done");
    i_over_current = 1'b1;
    run_starts(1, 1'b0, 1'b1);
    pulse_width(1000, w);
    check_in("blanked pulse", w, BLANK + 1, BLANK + 3);
    sw_seen = 1'b0;
    repeat (300) @(negedge i_mclk);
    check("off rest of cycle", 32'(sw_seen), 32'h0);
    i_over_current = 1'b0;
    pulse_width(20, w);
    check_in("max duty pulse", w, MAXD - 3, MAXD + 1);
    check("max duty flag", 32'(o_max_duty_limit), 32'h1);
    mode = 2'h0;
    w = 0;
    repeat (40) begin
      wait_start();
      w += int'(o_switch_on === 1'b1);
    end
    check_in("regulated pulses", w, 5, 35);
    $display("test pulses done");
    run_starts(6, 1'b0, 1'b1);
    check("limit low", 32'(o_ilim_sel), 32'(OSCA_ILIM_LOW));
    run_starts(4, 1'b1, 1'b1);
    check("limit up", 32'(o_ilim_sel), 32'(OSCA_ILIM_RED));
    run_starts(1, 1'b0, 1'b1);
    run_starts(4, 1'b1, 1'b1);
    check("limit full", 32'(o_ilim_sel), 32'(OSCA_ILIM_FULL));
    run_starts(3, 1'b0, 1'b1);
    check("limit reduced", 32'(o_ilim_sel), 32'(OSCA_ILIM_RED));
    run_starts(3, 1'b0, 1'b1);
    check("limit further", 32'(o_ilim_sel), 32'(OSCA_ILIM_LOW));
    $display("test current limit done");
    run_starts(FAULT - 1, 1'b1, 1'b1);
    run_starts(1, 1'b0, 1'b1);
    run_starts(FAULT - 1, 1'b1, 1'b1);
    check("counter cleared", 32'(o_restart_off), 32'h0);
    run_starts(1, 1'b0, 1'b1);
    run_starts(FAULT, 1'b1, 1'b0);
    check("restart off", 32'(o_restart_off), 32'h1);
    // The pulse started before the off phase runs to its end
    while (o_switch_on !== 1'b0) @(negedge i_mclk);
    off_sw = 1'b0;
    count_off(w);
    check_in("off length", w, OFFC - 1, OFFC + 1);
    check("no switch off", 32'(off_sw), 32'h0);
    wait_start();
    check("switch resumes", 32'(o_switch_on), 32'h1);
    run_starts(1, 1'b0, 1'b1);
    $display("test auto-restart done");
    i_line_ok = 1'b0;
    repeat (5) @(negedge i_mclk);
    check("line uv run", 32'(o_line_uv), 32'h1);
    check("no hold in run", 32'(o_supply_hold), 32'h0);
    run_starts(FAULT - 1, 1'b1, 1'b1);
    run_starts(1, 1'b1, 1'b0);
    while (o_switch_on !== 1'b0) @(negedge i_mclk);
    off_sw = 1'b0;
    repeat (30) wait_start();
    check("frozen off", 32'(o_restart_off), 32'h1);
    check("stays off", 32'(off_sw), 32'h0);
    i_line_ok = 1'b1;
    count_off(w);
    check_in("off after uv", w, OFFC - 1, OFFC + 1);
    run_starts(1, 1'b0, 1'b1);
    i_sense_absent = 1'b1;
    i_line_ok = 1'b0;
    repeat (5) @(negedge i_mclk);
    check("uv disabled", 32'(o_line_uv), 32'h0);
    run_starts(1, 1'b1, 1'b1);
    $display("test line undervoltage done");
    complete_run();
  end
endmodule
